// >>> design/dcp_channel.sv
// one detector channel: switch capture, output encoding, panel editor, ahb
`timescale 1ns/1ns
`default_nettype none
module dcp_channel #(
  parameter int unsigned HOLD_CYCLES   = dcp_pkg::HOLD_CYC,
  parameter int unsigned IDLE_CYCLES   = dcp_pkg::IDLE_CYC,
  parameter int unsigned DEB_CYCLES    = dcp_pkg::DEB_CYC,
  parameter int unsigned REPEAT_CYCLES = dcp_pkg::REPEAT_CYC
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire dcp_pkg::dcp_sw_t switch_pins,
  input  wire logic             aux_pin,
  input  wire logic             button_pin,
  input  wire logic             fault_pin,
  output logic                  single_output,
  output logic                  double_output,
  output logic                  fault_output,
  output logic                  sinking_drive,
  output logic                  high_speed,
  output logic                  material_steel,
  output logic [6:0]            overlap_pct,
  output dcp_pkg::dcp_dsp_t     display_code,
  output logic [15:0]           display_value
);
  import dcp_pkg::*;

  // ==========================================================================
  // elaboration checks
  if (HOLD_CYCLES == 0 || IDLE_CYCLES == 0 || DEB_CYCLES == 0 ||
      REPEAT_CYCLES == 0 || HOLD_CYCLES >= 2**CNT_W ||
      IDLE_CYCLES >= 2**CNT_W) begin : g_bad
    $error("dcp_channel: cycle counts out of range");
  end

  localparam logic [CNT_W-1:0] HOLD_N = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] IDLE_N = CNT_W'(IDLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] DEB_N  = CNT_W'(DEB_CYCLES - 1);
  localparam logic [CNT_W-1:0] REP_N  = CNT_W'(REPEAT_CYCLES - 1);

  // percent of a value, rounded down
  function automatic logic [15:0] pct_of(input logic [15:0] v,
                                         input logic [6:0]  p);
    logic [22:0] prod;
    prod   = 23'(v) * 23'(p);
    pct_of = 16'(prod / PCT_DIV);
  endfunction

  // next editable item after cur, in order tolerance, overlap, direction
  function automatic dcp_item_t next_item(input dcp_item_t cur,
                                          input logic adj,
                                          input logic ovl);
    next_item = ITEM_DIR;
    unique case (cur)
      ITEM_TOL: next_item = ovl ? ITEM_OVL : ITEM_DIR;
      ITEM_OVL: next_item = ITEM_DIR;
      default:  next_item = adj ? ITEM_TOL : (ovl ? ITEM_OVL : ITEM_DIR);
    endcase
  endfunction

  // ==========================================================================
  // pin synchronisers, two flops before any use
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {fault_pin, button_pin, aux_pin, switch_pins};
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================================
  // power-up switch capture; later switch moves are never looked at again
  dcp_sw_t    cfg_q;
  logic [1:0] cap_cnt_q;
  logic       cap_done_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q      <= '0;
      cap_cnt_q  <= 2'h0;
      cap_done_q <= 1'b0;
    end else if (!cap_done_q) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == 2'h3) begin
        cfg_q      <= dcp_sw_t'(sync2_q[5:0]); // R1
        cap_done_q <= 1'b1;
      end
    end
  end
  a_switch_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(cap_done_q) |-> $stable(cfg_q)) else $error("switches changed"); // R1

  wire adj_en = cfg_q.threshold_adjust_switch;
  wire ovl_en = cfg_q.overlap_enable_switch & cfg_q.speed_mode_switch; // R6

  // ==========================================================================
  // debounce of button and auxiliary; a level must hold DEB_CYCLES to count
  logic [1:0]       deb_q;
  logic [CNT_W-1:0] deb_cnt_q [2];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deb_q        <= 2'h0;
      deb_cnt_q[0] <= '0;
      deb_cnt_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync2_q[6+i] == deb_q[i]) begin
          deb_cnt_q[i] <= '0;
        end else if (deb_cnt_q[i] == DEB_N) begin
          deb_q[i]     <= sync2_q[6+i]; // R23
          deb_cnt_q[i] <= '0;
        end else begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
        end
      end
    end
  end
  wire aux_db = deb_q[0];
  wire btn_db = deb_q[1];
  logic btn_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_prev_q <= 1'b0;
    end else begin
      btn_prev_q <= btn_db;
    end
  end
  wire press = btn_db & ~btn_prev_q; // one event per debounced press

  // ==========================================================================
  // software registers: calibration value, signal sample, tab tolerance
  logic [15:0] cal_q;
  logic [15:0] signal_q;
  logic [6:0]  tab_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_q    <= CAL_DEFAULT;
      signal_q <= 16'h0000;
      tab_q    <= TAB_DEFAULT;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        OFS_CAL:    cal_q    <= hwdata[15:0];
        OFS_SIGNAL: signal_q <= hwdata[15:0];
        OFS_TAB:    tab_q    <= (hwdata[6:0] < PCT_MIN) ? PCT_MIN :   // R20
                                (hwdata[6:0] > PCT_MAX || hwdata[31:7] != '0)
                                ? PCT_MAX : hwdata[6:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // panel editor: hold to reach a prompt, release to edit, idle to leave
  dcp_state_t       st_q;
  dcp_item_t        sel_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic [CNT_W-1:0] idle_cnt_q;
  logic [6:0]       tol_q;
  logic [6:0]       ovl_q;
  logic             dir_q;
  wire bump = (st_q == ST_EDIT) && (press || (btn_db && hold_cnt_q == REP_N
                                    && sel_q != ITEM_DIR));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= ST_GAUGE;
      sel_q      <= ITEM_DIR;
      hold_cnt_q <= '0;
      idle_cnt_q <= '0;
    end else begin
      hold_cnt_q <= btn_db ? hold_cnt_q + 1'b1 : '0;
      unique case (st_q)
        ST_GAUGE: if (btn_db && hold_cnt_q == HOLD_N) begin
          st_q       <= ST_PROMPT; // R10 R13
          sel_q      <= next_item(ITEM_DIR, adj_en, ovl_en);
          hold_cnt_q <= '0;
        end
        ST_PROMPT: if (!btn_db) begin
          st_q       <= ST_EDIT;
          idle_cnt_q <= '0;
        end else if (hold_cnt_q == HOLD_N) begin
          sel_q      <= next_item(sel_q, adj_en, ovl_en);
          hold_cnt_q <= '0;
        end
        ST_EDIT: begin
          if (bump) begin
            hold_cnt_q <= '0;
          end
          if (btn_db) begin
            idle_cnt_q <= '0;
          end else if (idle_cnt_q == IDLE_N) begin
            st_q <= ST_WAIT; // R12 R15 R17
          end else begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
          end
        end
        ST_WAIT: st_q <= ST_GAUGE; // one cycle so the leave is seen cleanly
        default: st_q <= ST_GAUGE;
      endcase
    end
  end

  // edited values; only the selected one moves, the others are kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tol_q <= TOL_DEFAULT; // R19
      ovl_q <= OVL_DEFAULT;
      dir_q <= 1'b0;
    end else if (bump) begin
      unique case (sel_q)
        ITEM_TOL: if (adj_en) begin // R5
          tol_q <= (tol_q >= PCT_MAX) ? PCT_MIN : tol_q + 7'h01; // R11
        end
        ITEM_OVL: if (ovl_en) begin // R6
          ovl_q <= (ovl_q >= PCT_MAX) ? OVL_MIN : ovl_q + 7'h01; // R14
        end
        default: dir_q <= ~dir_q; // R16
      endcase
    end
  end
  wire [6:0] tol_eff = adj_en ? tol_q : TOL_DEFAULT; // R5

  a_tol_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    (tol_q == PCT_MAX && bump && sel_q == ITEM_TOL && adj_en) |=>
    tol_q == PCT_MIN) else $error("tolerance did not wrap to 10"); // R11
  a_ovl_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    (ovl_q == PCT_MAX && bump && sel_q == ITEM_OVL && ovl_en) |=>
    ovl_q == OVL_MIN) else $error("overlap did not wrap to 0"); // R14
  a_tol_range: assert property (@(posedge hclk) disable iff (!hresetn)
    tol_q >= PCT_MIN && tol_q <= PCT_MAX && tab_q >= PCT_MIN &&
    tab_q <= PCT_MAX) else $error("tolerance out of range"); // R19 R20
  a_dir_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_EDIT && sel_q == ITEM_DIR && press) |=>
    dir_q != $past(dir_q)) else $error("direction not toggled"); // R16
  a_idle_leave: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_EDIT && !btn_db && idle_cnt_q == IDLE_N) |=> ##1
    (st_q == ST_GAUGE && display_code == DSP_GAUGE))
    else $error("edit not left after idle"); // R12 R15 R17

  // ==========================================================================
  // gap classification against the two thresholds
  logic [15:0] dbl_thr_q;
  logic [16:0] miss_thr_q;
  dcp_gap_t    gap_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbl_thr_q  <= 16'h0000;
      miss_thr_q <= 17'h1ffff;
      gap_q      <= GAP_MISSING;
    end else begin
      dbl_thr_q  <= cal_q - pct_of(cal_q, tol_eff); // R9
      miss_thr_q <= 17'(cal_q) + 17'(pct_of(cal_q, tab_q));
      if (signal_q < dbl_thr_q) begin
        gap_q <= GAP_DOUBLE; // R9
      end else if (17'(signal_q) > miss_thr_q) begin
        gap_q <= GAP_MISSING;
      end else begin
        gap_q <= GAP_SINGLE;
      end
    end
  end
  a_double_class: assert property (@(posedge hclk) disable iff (!hresetn)
    (signal_q < dbl_thr_q) |=> gap_q == GAP_DOUBLE)
    else $error("low signal not a double"); // R9

  // ==========================================================================
  // detector outputs and mode selects
  logic       single_q;
  logic       double_q;
  logic       fault_q;
  logic       sinking_q;
  logic       speed_q;
  logic       steel_q;
  logic [6:0] ovl_out_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      single_q  <= 1'b0;
      double_q  <= 1'b0;
      fault_q   <= 1'b0;
      sinking_q <= 1'b0;
      speed_q   <= 1'b0;
      steel_q   <= 1'b0;
      ovl_out_q <= 7'h00;
    end else begin
      if (cfg_q.output_encoding_switch) begin
        single_q <= (gap_q == GAP_MISSING); // R8
        double_q <= (gap_q == GAP_DOUBLE);  // R8
      end else begin
        single_q <= (gap_q != GAP_MISSING); // R7
        double_q <= (gap_q != GAP_DOUBLE);  // R7
      end
      fault_q   <= ~sync2_q[8];                               // R22
      sinking_q <= cfg_q.driver_polarity_switch;              // R4
      speed_q   <= cfg_q.speed_mode_switch;                   // R3
      steel_q   <= cfg_q.material_select_switch ^ aux_db;     // R2
      ovl_out_q <= ovl_en ? ovl_q : 7'h00;                    // R6 R21
    end
  end
  a_failsafe_map: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg_q.output_encoding_switch && $stable(cfg_q) |=>
    single_q == ($past(gap_q) != GAP_MISSING) &&
    double_q == ($past(gap_q) != GAP_DOUBLE))
    else $error("fail-safe encoding wrong"); // R7
  a_compat_map: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_q.output_encoding_switch && $stable(cfg_q) |=>
    single_q == ($past(gap_q) == GAP_MISSING) &&
    double_q == ($past(gap_q) == GAP_DOUBLE))
    else $error("compatibility encoding wrong"); // R8
  a_material_xor: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(cfg_q) |=> steel_q ==
    ($past(cfg_q.material_select_switch) ^ $past(aux_db)))
    else $error("material select wrong"); // R2
  a_mode_map: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(cfg_q) |=> speed_q == $past(cfg_q.speed_mode_switch) &&
    sinking_q == $past(cfg_q.driver_polarity_switch))
    else $error("speed or polarity select wrong"); // R3 R4
  a_overlap_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !(cfg_q.overlap_enable_switch && cfg_q.speed_mode_switch) |=>
    ovl_out_q == 7'h00) else $error("overlap allowed while off"); // R6 R21
  a_fault_out: assert property (@(posedge hclk) disable iff (!hresetn)
    sync2_q[8] |=> !fault_q) else $error("fault output on in fault"); // R22

  // ==========================================================================
  // display: prompt, edited value, or gauge in the chosen direction
  dcp_dsp_t    dsp_q;
  logic [15:0] dval_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsp_q  <= DSP_GAUGE;
      dval_q <= 16'h0000;
    end else begin
      dsp_q  <= DSP_GAUGE;
      dval_q <= dir_q ? ~signal_q : signal_q; // R18
      if (st_q == ST_PROMPT) begin
        dsp_q <= (sel_q == ITEM_TOL) ? DSP_TOL_PROMPT :
                 (sel_q == ITEM_OVL) ? DSP_OVL_PROMPT : DSP_DIR_PROMPT;
      end else if (st_q == ST_EDIT) begin
        dsp_q  <= (sel_q == ITEM_TOL) ? DSP_TOL_VAL :
                  (sel_q == ITEM_OVL) ? DSP_OVL_VAL : DSP_DIR_VAL;
        dval_q <= (sel_q == ITEM_TOL) ? 16'(tol_eff) :
                  (sel_q == ITEM_OVL) ? 16'(ovl_q) : 16'(dir_q);
      end
    end
  end

  // ==========================================================================
  // ahb-lite slave: zero wait states, read data caught in the address phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_CAL:    rd_mux = {16'h0000, cal_q};
      OFS_SIGNAL: rd_mux = {16'h0000, signal_q};
      OFS_TAB:    rd_mux = {25'h0000000, tab_q};
      OFS_CONFIG: rd_mux = {23'h000000, ovl_en, steel_q, cap_done_q,
                            cfg_q};
      OFS_PARAMS: rd_mux = {8'h00, 7'h00, dir_q, 1'b0, ovl_q, 1'b0, tol_eff};
      OFS_STATUS: rd_mux = {dbl_thr_q, 11'h000, fault_q, double_q,
                            single_q, gap_q};
      default:    rd_mux = 32'h0000_0000;
    endcase
    if (haddr[31:8] != '0) begin
      rd_mux = 32'h0000_0000;
    end
  end
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= take && hwrite && hsize == 3'h2 && haddr[31:8] == '0;
      wr_addr_q <= haddr[7:0];
      hreadyout <= 1'b1; // never stretches a transfer
      hresp     <= 1'b0; // always okay, unmapped reads zero
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  assign single_output  = single_q;
  assign double_output  = double_q;
  assign fault_output   = fault_q;
  assign sinking_drive  = sinking_q;
  assign high_speed     = speed_q;
  assign material_steel = steel_q;
  assign overlap_pct    = ovl_out_q;
  assign display_code   = dsp_q;
  assign display_value  = dval_q;
endmodule
`default_nettype wire

// >>> shared/dcp_pkg.sv
// constants and types of the detector channel configuration and panel editor
// ============================================================================
// What this block does
// [R1] option switches are captured once after power-up, later changes ignored
// [R2] material is steel when material switch xor auxiliary input is on
// [R3] speed-mode switch off gives on-press timing, on gives high-speed timing
// [R4] polarity switch off selects sourcing drivers, on selects sinking
// [R5] tolerance edit only with threshold switch on, otherwise fixed value
// [R6] overlap and its edit only with overlap and speed switches both on
// [R7] fail-safe: missing 0/1, single 1/1, double 1/0 on single/double
// [R8] compatibility: missing 1/0, single 0/0, double 0/1 on single/double
// [R9] double when signal below calibration minus calibration times tolerance
// [R10] three second hold with adjustable thresholds shows tolerance prompt
// [R11] tolerance edit: tap or hold increments, after 90 wraps to 10
// [R12] five idle seconds end tolerance edit, last value kept
// [R13] three second hold with overlap enabled shows overlap prompt
// [R14] overlap edit: tap or hold increments, after 90 wraps to 0
// [R15] five idle seconds end overlap edit, last value kept
// [R16] direction edit: each press toggles 0 normal and 1 inverted
// [R17] five idle seconds return to gauge in the selected direction
// [R18] normal display follows signal, inverted follows thickness
// [R19] double tolerance limited to 10 through 90, default 35
// [R20] tab tolerance limited to 10 through 90, default 15
// [R21] overlap 0 through 90, applies only in high-speed sensing
// [R22] fault output on without fault, off while any channel fault present
// [R23] button and auxiliary inputs synchronised and debounced
package dcp_pkg;
  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned HOLD_S      = 3;
  localparam int unsigned IDLE_S      = 5;
  localparam int unsigned DEB_MS      = 10;
  localparam int unsigned REPEAT_MS   = 400;
  localparam int unsigned HOLD_CYC    = HOLD_S * CLK_HZ;
  localparam int unsigned IDLE_CYC    = IDLE_S * CLK_HZ;
  localparam int unsigned DEB_CYC     = DEB_MS * (CLK_HZ / 1000);
  localparam int unsigned REPEAT_CYC  = REPEAT_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W       = 31;
  // ==========================================================================
  // parameter limits and defaults
  localparam logic [6:0] PCT_MIN     = 7'h0a;
  localparam logic [6:0] PCT_MAX     = 7'h5a;
  localparam logic [6:0] OVL_MIN     = 7'h00;
  localparam logic [6:0] TOL_DEFAULT = 7'h23;
  localparam logic [6:0] TAB_DEFAULT = 7'h0f;
  localparam logic [6:0] OVL_DEFAULT = 7'h00;
  localparam logic [15:0] CAL_DEFAULT = 16'h0032;
  localparam logic [22:0] PCT_DIV    = 23'h000064;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_CAL    = 8'h00;
  localparam logic [7:0] OFS_SIGNAL = 8'h04;
  localparam logic [7:0] OFS_TAB    = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_PARAMS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // ==========================================================================
  // types
  typedef struct packed {
    logic overlap_enable_switch;
    logic driver_polarity_switch;
    logic threshold_adjust_switch;
    logic output_encoding_switch;
    logic speed_mode_switch;
    logic material_select_switch;
  } dcp_sw_t;
  typedef enum logic [1:0] {
    GAP_MISSING = 2'h0, GAP_SINGLE = 2'h1, GAP_DOUBLE = 2'h2
  } dcp_gap_t;
  typedef enum logic [1:0] {
    ITEM_TOL = 2'h0, ITEM_OVL = 2'h1, ITEM_DIR = 2'h2
  } dcp_item_t;
  typedef enum logic [2:0] {
    DSP_GAUGE = 3'h0, DSP_TOL_PROMPT = 3'h1, DSP_OVL_PROMPT = 3'h2,
    DSP_DIR_PROMPT = 3'h3, DSP_TOL_VAL = 3'h4, DSP_OVL_VAL = 3'h5,
    DSP_DIR_VAL = 3'h6
  } dcp_dsp_t;
  typedef enum logic [3:0] {
    ST_GAUGE = 4'b0001, ST_PROMPT = 4'b0010, ST_EDIT = 4'b0100,
    ST_WAIT = 4'b1000
  } dcp_state_t;
endpackage

// >>> tb/dcp_plc_model.sv
// plc side model that decodes the channel outputs into gap and fault states
`timescale 1ns/1ns
`default_nettype none
module dcp_plc_model (
  input  wire logic          hclk,
  input  wire logic          encoding,
  input  wire logic          single_output,
  input  wire logic          double_output,
  input  wire logic          fault_output,
  output var dcp_pkg::dcp_gap_t seen_gap,
  output var logic           seen_fault
);
  import dcp_pkg::*;
  // ==========================================================================
  // input card scan, one sample a clock; an undecodable pair reads as double
  always_ff @(posedge hclk) begin
    seen_fault <= !fault_output;
    case ({encoding, single_output, double_output})
      3'b001, 3'b110: seen_gap <= GAP_MISSING;
      3'b011, 3'b100: seen_gap <= GAP_SINGLE;
      default:        seen_gap <= GAP_DOUBLE;
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for one detector channel
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dcp_pkg::*;
  // short counts keep the run small; expectations follow them
  localparam int HC = 40;
  localparam int IC = 60;
  typedef struct packed {
    logic [5:0]  sw;
    logic        aux;
    logic [15:0] sig;
    logic        s;
    logic        d;
    dcp_gap_t    gap;
  } dcp_row_t;
  logic        hclk, hresetn, hsel, hwrite, aux_pin, button_pin, fault_pin;
  logic [31:0] haddr, hwdata, rd, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  sw;
  logic        hreadyout, hresp, single_output, double_output, fault_output;
  logic        sinking_drive, high_speed, material_steel, seen_fault;
  logic [6:0]  overlap_pct;
  logic [15:0] display_value;
  dcp_dsp_t    display_code;
  dcp_gap_t    seen_gap;
  int          bad_count, cmp_count;
  dcp_row_t rows [6] = '{
    '{6'h00, 1'b0, 16'h0064, 1'b0, 1'b1, GAP_MISSING},
    '{6'h01, 1'b0, 16'h0032, 1'b1, 1'b1, GAP_SINGLE},
    '{6'h21, 1'b1, 16'h0014, 1'b1, 1'b0, GAP_DOUBLE},
    '{6'h04, 1'b1, 16'h0064, 1'b1, 1'b0, GAP_MISSING},
    '{6'h16, 1'b0, 16'h0032, 1'b0, 1'b0, GAP_SINGLE},
    '{6'h27, 1'b0, 16'h0014, 1'b0, 1'b1, GAP_DOUBLE}};
  // ==========================================================================
  // design, far side model and clock
  dcp_channel #(.HOLD_CYCLES(HC), .IDLE_CYCLES(IC), .DEB_CYCLES(4),
    .REPEAT_CYCLES(10)) dcp_channel_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .switch_pins(sw), .aux_pin(aux_pin), .button_pin(button_pin),
    .fault_pin(fault_pin), .single_output(single_output),
    .double_output(double_output), .fault_output(fault_output),
    .sinking_drive(sinking_drive), .high_speed(high_speed),
    .material_steel(material_steel), .overlap_pct(overlap_pct),
    .display_code(display_code), .display_value(display_value));
  dcp_plc_model dcp_plc_model_i (.hclk(hclk), .encoding(sw[2]),
    .single_output(single_output), .double_output(double_output),
    .fault_output(fault_output), .seen_gap(seen_gap),
    .seen_fault(seen_fault));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ==========================================================================
  // tasks
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // bounded wait for hready at a rising edge
  task wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      close_out();
    end
  endtask
  // one single word transfer; hsel stays up, idle htrans separates transfers
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // reset stands for power-up, switches set before release
  task boot(input logic [5:0] s);
    sw <= s;
    hresetn <= 1'b0;
    cyc(4);
    hresetn <= 1'b1;
    cyc(8);
  endtask
  // press and release long enough to pass the debounce, short of repeat
  task tap(input int n);
    repeat (n) begin
      button_pin <= 1'b1;
      cyc(8);
      button_pin <= 1'b0;
      cyc(8);
    end
  endtask
  task enter(input dcp_dsp_t p, input dcp_dsp_t v, input logic [15:0] v0);
    button_pin <= 1'b1;
    cyc(HC + 16);
    chk("prompt", p, display_code);
    button_pin <= 1'b0;
    cyc(12);
    chk("item", v, display_code);
    chk("start", v0, display_value);
  endtask
  task idle();
    cyc(IC + 10);
    chk("gauge", DSP_GAUGE, display_code);
  endtask
  task close_out();
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {hresetn, hwrite, aux_pin, button_pin, fault_pin} = 5'h00;
    {haddr, hwdata, htrans, sw} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    bad_count = 0;
    cmp_count = 0;
    foreach (rows[i]) begin
      aux_pin <= rows[i].aux;
      boot(rows[i].sw);
      bus(1'b1, OFS_SIGNAL, {16'h0000, rows[i].sig});
      cyc(4);
      chk("single", rows[i].s, single_output);
      chk("double", rows[i].d, double_output);
      chk("gap", rows[i].gap, seen_gap);
      chk("steel", rows[i].sw[0] ^ rows[i].aux, material_steel);
      chk("speed", rows[i].sw[1], high_speed);
      chk("sink", rows[i].sw[4], sinking_drive);
      chk("no fault", 1'b1, fault_output);
      chk("gauge", rows[i].sig, display_value);
      bus(1'b0, OFS_CONFIG, 32'h0);
      chk("ovl on", rows[i].sw[5] & rows[i].sw[1], rd[8]);
    end
    sw <= 6'h18;
    cyc(10);
    chk("frozen", 1'b0, sinking_drive);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("cfg", 6'h27, rd[5:0]);
    fault_pin <= 1'b1;
    cyc(6);
    chk("fault", 1'b0, fault_output);
    chk("plc fault", 1'b1, seen_fault);
    fault_pin <= 1'b0;
    bus(1'b0, OFS_CAL, 32'h0);
    chk("cal", CAL_DEFAULT, rd[15:0]);
    bus(1'b0, OFS_TAB, 32'h0);
    chk("tab", TAB_DEFAULT, rd[6:0]);
    bus(1'b1, OFS_TAB, 32'h5);
    bus(1'b0, OFS_TAB, 32'h0);
    chk("tab low", PCT_MIN, rd[6:0]);
    bus(1'b1, OFS_TAB, 32'h63);
    bus(1'b0, OFS_TAB, 32'h0);
    chk("tab high", PCT_MAX, rd[6:0]);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    // tolerance edit and its effect on the double threshold
    boot(6'h08);
    enter(DSP_TOL_PROMPT, DSP_TOL_VAL, 16'h0023);
    tap(55);
    chk("tol top", 16'h005a, display_value);
    tap(1);
    chk("tol wrap", 16'h000a, display_value);
    idle();
    bus(1'b0, OFS_PARAMS, 32'h0);
    chk("tol kept", 7'h0a, rd[6:0]);
    bus(1'b1, OFS_SIGNAL, 32'h28);
    cyc(4);
    chk("dbl 10pct", GAP_DOUBLE, seen_gap);
    // overlap edit
    boot(6'h22);
    enter(DSP_OVL_PROMPT, DSP_OVL_VAL, 16'h0000);
    tap(90);
    chk("ovl top", 16'h005a, display_value);
    tap(1);
    chk("ovl wrap", 16'h0000, display_value);
    tap(5);
    idle();
    chk("ovl kept", 7'h05, overlap_pct);
    // direction edit, the only item with both switches off
    boot(6'h00);
    bus(1'b1, OFS_SIGNAL, 32'h32);
    enter(DSP_DIR_PROMPT, DSP_DIR_VAL, 16'h0000);
    tap(1);
    chk("dir", 16'h0001, display_value);
    idle();
    chk("inverted", 16'hffcd, display_value);
    chk("okay", 1'b0, hresp);
    close_out();
  end
endmodule
`default_nettype wire
